// >>> common/psw_pkg.sv
// Package of constants and types for the status word and exception unit
`default_nettype none
package psw_pkg;
    localparam int          WORD_W        = 32;
    // Status word field positions
    localparam int          BIT_N         = 31;
    localparam int          BIT_Z         = 30;
    localparam int          BIT_C         = 29;
    localparam int          BIT_V         = 28;
    localparam int          BIT_I         = 7;
    localparam int          BIT_F         = 6;
    localparam int          BIT_T         = 5;
    localparam int          CTRL_W        = 8;
    // Mode encodings
    localparam logic [4:0]  MODE_USR      = 5'h10;
    localparam logic [4:0]  MODE_FIQ      = 5'h11;
    localparam logic [4:0]  MODE_IRQ      = 5'h12;
    localparam logic [4:0]  MODE_SVC      = 5'h13;
    localparam logic [4:0]  MODE_ABT      = 5'h17;
    localparam logic [4:0]  MODE_UND      = 5'h1B;
    localparam logic [4:0]  MODE_SYS      = 5'h1F;
    // Vector addresses
    localparam logic [31:0] VEC_RESET     = 32'h00000000;
    localparam logic [31:0] VEC_UND       = 32'h00000004;
    localparam logic [31:0] VEC_SWT       = 32'h00000008;
    localparam logic [31:0] VEC_PREFETCH_ABORT      = 32'h0000000C;
    localparam logic [31:0] VEC_DATA_ABORT      = 32'h00000010;
    localparam logic [31:0] VEC_IRQ       = 32'h00000018;
    localparam logic [31:0] VEC_FIQ       = 32'h0000001C;
    // Link offsets
    localparam logic [31:0] LINK_OFS2     = 32'h00000002;
    localparam logic [31:0] LINK_OFS4     = 32'h00000004;
    localparam logic [31:0] LINK_OFS8     = 32'h00000008;
    // Register port offsets
    localparam logic [3:0]  ADDR_CUR      = 4'h0;
    localparam logic [3:0]  ADDR_SAVED    = 4'h1;
    localparam logic [3:0]  ADDR_LINK     = 4'h2;
    localparam logic [3:0]  ADDR_PC       = 4'h3;
    localparam logic [3:0]  ADDR_RETURN   = 4'h4;
    // Reset status: supervisor, both masks set, full state
    localparam logic [31:0] CUR_RESET     = 32'h000000D3;
    localparam logic [31:0] ZERO_WORD     = 32'h00000000;
    // Saved-word bank slots
    localparam logic [2:0]  SLOT_FIQ      = 3'h0;
    localparam logic [2:0]  SLOT_IRQ      = 3'h1;
    localparam logic [2:0]  SLOT_SVC      = 3'h2;
    localparam logic [2:0]  SLOT_ABT      = 3'h3;
    localparam logic [2:0]  SLOT_UND      = 3'h4;
    localparam logic [2:0]  SLOT_NONE     = 3'h7;
    localparam int          SLOTS         = 5;

    typedef enum logic [2:0] {
        EXC_NONE, EXC_DATA_ABORT, EXC_FIQ, EXC_IRQ, EXC_PREFETCH_ABORT, EXC_UND, EXC_SWT, EXC_BL
    } psw_exc_type;
endpackage : psw_pkg
`default_nettype wire

// >>> verilog/psw_bank_mem.sv
// Small memory holding banked words, registered read
`default_nettype none
module psw_bank_mem #(
    parameter int DEPTH = 5,
    parameter int WIDTH = 32
) (
    input  wire logic             clk_i,
    input  wire logic             we_i,
    input  wire logic [2:0]       waddr_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    input  wire logic [2:0]       raddr_i,
    output logic      [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem_ff [DEPTH];

    // No reset: banked contents are undefined until first written
    always_ff @(posedge clk_i) begin
        if (we_i && (int'(waddr_i) < DEPTH)) begin
            mem_ff[waddr_i] <= wdata_i;
        end
        if (int'(raddr_i) < DEPTH) begin
            rdata_o <= mem_ff[raddr_i];
        end else begin
            rdata_o <= '0;
        end
    end
endmodule : psw_bank_mem
`default_nettype wire

// >>> verilog/psw_prio_sel.sv
// Fixed priority selection among pending exceptions
`default_nettype none
module psw_prio_sel (
    input  wire logic                 data_abort_i,
    input  wire logic                 fiq_i,
    input  wire logic                 irq_i,
    input  wire logic                 prefetch_abort_i,
    input  wire logic                 und_i,
    input  wire logic                 swt_i,
    input  wire logic                 bl_i,
    output psw_pkg::psw_exc_type      sel_o
);
    assign sel_o = data_abort_i ? psw_pkg::EXC_DATA_ABORT :
                   fiq_i  ? psw_pkg::EXC_FIQ  :
                   irq_i  ? psw_pkg::EXC_IRQ  :
                   prefetch_abort_i ? psw_pkg::EXC_PREFETCH_ABORT :
                   und_i  ? psw_pkg::EXC_UND  :
                   swt_i  ? psw_pkg::EXC_SWT  :
                   bl_i   ? psw_pkg::EXC_BL   : psw_pkg::EXC_NONE;
endmodule : psw_prio_sel
`default_nettype wire

// >>> verilog/psw_exc_unit.sv
// Status word and exception entry/exit unit
// Notes on behaviour
// - compact low regs, SP/LR/PC map to 13-15
// - one current word, five saved words
// - low 8 bits writable only when privileged
// - state bit selects compact, driven on pin
// - mask bits block normal and fast interrupts
// - mode field encodings select operating mode
// - fast mode banks 8-14, others 13-14
// - flags updated by ALU, gate conditions
// - compact high regs via move/compare/add only
// - entry saves return address in banked link
// - entry copies current word to saved word
// - entry forces mode and vector fetch
// - entry may set interrupt masks
// - exception switches to full state
// - compact-state link adjusted, PC+2 traps
// - link PC+4, data abort PC+8
// - return restores state bit from saved word
// - supervisor link undefined after reset
// - fixed vector addresses per exception
// - fixed priority among simultaneous exceptions
`default_nettype none
module psw_exc_unit (
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    // Register port
    input  wire logic [3:0]  ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [31:0] RDATA_O,
    // Datapath side
    input  wire logic [31:0] PC_I,
    input  wire logic        FLAGS_WE_I,
    input  wire logic [3:0]  FLAGS_I,
    input  wire logic [3:0]  COND_I,
    input  wire logic        INSN_END_I,
    input  wire logic        BL_I,
    input  wire logic        SWT_I,
    input  wire logic        UND_I,
    input  wire logic        PREFETCH_ABORT_I,
    input  wire logic        HI_ACCESS_I,
    input  wire logic        HI_LEGAL_I,
    input  wire logic [3:0]  REG_SEL_I,
    // External sources (asynchronous pins)
    input  wire logic        FIQ_N_I,
    input  wire logic        IRQ_N_I,
    input  wire logic        DATA_ABORT_I,
    // Outputs
    output logic             COMPACT_STATE_O,
    output logic [4:0]       MODE_O,
    output logic             COND_PASS_O,
    output logic             HI_FAULT_O,
    output logic [5:0]       PHYS_REG_O,
    output logic             FETCH_REDIRECT_O,
    output logic [31:0]      FETCH_ADDR_O,
    output logic             LINK_WE_O,
    output logic [31:0]      LINK_DATA_O,
    output logic             BUSY_O
);
    typedef enum logic [1:0] {ST_IDLE, ST_SAVE, ST_FETCH} psw_state_type;

    logic [31:0]        cur_ff;
    logic [31:0]        nxt_cur;
    psw_state_type      st_ff;
    psw_state_type      nxt_st;
    psw_pkg::psw_exc_type exc_ff;
    logic [31:0]        pc_ff;
    logic               tstate_ff;
    logic [2:0]         rd_slot_ff;
    logic               rd_saved_ff;
    logic [1:0]         fiq_sync_ff;
    logic [1:0]         irq_sync_ff;
    logic [1:0]         data_abort_sync_ff;
    logic [31:0]        saved_rdata;
    psw_pkg::psw_exc_type sel;

    // Slot of the saved word for a mode; user and system have none
    function automatic logic [2:0] slot_of(input logic [4:0] m);
        if (m == psw_pkg::MODE_FIQ) return psw_pkg::SLOT_FIQ;
        else if (m == psw_pkg::MODE_IRQ) return psw_pkg::SLOT_IRQ;
        else if (m == psw_pkg::MODE_SVC) return psw_pkg::SLOT_SVC;
        else if (m == psw_pkg::MODE_ABT) return psw_pkg::SLOT_ABT;
        else if (m == psw_pkg::MODE_UND) return psw_pkg::SLOT_UND;
        else return psw_pkg::SLOT_NONE;
    endfunction : slot_of

    function automatic logic [4:0] mode_of(input psw_pkg::psw_exc_type e);
        case (e)
            psw_pkg::EXC_FIQ:  return psw_pkg::MODE_FIQ;
            psw_pkg::EXC_IRQ:  return psw_pkg::MODE_IRQ;
            psw_pkg::EXC_SWT:  return psw_pkg::MODE_SVC;
            psw_pkg::EXC_UND:  return psw_pkg::MODE_UND;
            default:           return psw_pkg::MODE_ABT;
        endcase
    endfunction : mode_of

    // Current mode field and privilege
    wire logic [4:0] cur_mode   = cur_ff[4:0];
    wire logic       privileged = (cur_mode != psw_pkg::MODE_USR);
    wire logic       cur_t      = cur_ff[psw_pkg::BIT_T];

    // Input synchronisers: first stage is read only by the second
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            fiq_sync_ff  <= 2'h3;
            irq_sync_ff  <= 2'h3;
            data_abort_sync_ff <= 2'h0;
        end else begin
            fiq_sync_ff  <= {fiq_sync_ff[0], FIQ_N_I};
            irq_sync_ff  <= {irq_sync_ff[0], IRQ_N_I};
            data_abort_sync_ff <= {data_abort_sync_ff[0], DATA_ABORT_I};
        end
    end

    wire logic fiq_req  = !fiq_sync_ff[1] && !cur_ff[psw_pkg::BIT_F];
    wire logic irq_req  = !irq_sync_ff[1] && !cur_ff[psw_pkg::BIT_I];
    wire logic data_abort_req = data_abort_sync_ff[1];

    // Sources are only recognised in idle, at an instruction boundary
    wire logic take = (st_ff == ST_IDLE) && INSN_END_I;

    psw_prio_sel u_prio (
        .data_abort_i (take && data_abort_req),
        .fiq_i  (take && fiq_req),
        .irq_i  (take && irq_req),
        .prefetch_abort_i (take && PREFETCH_ABORT_I),
        .und_i  (take && UND_I),
        .swt_i  (take && SWT_I),
        .bl_i   (take && BL_I),
        .sel_o  (sel)
    );

    wire logic is_trap = (sel != psw_pkg::EXC_NONE) && (sel != psw_pkg::EXC_BL);

    // Link value per exception kind and entry state
    wire logic [31:0] link_ofs =
        (exc_ff == psw_pkg::EXC_DATA_ABORT) ? psw_pkg::LINK_OFS8 :
        ((exc_ff == psw_pkg::EXC_BL || exc_ff == psw_pkg::EXC_SWT ||
          exc_ff == psw_pkg::EXC_UND) && tstate_ff) ? psw_pkg::LINK_OFS2 :
        psw_pkg::LINK_OFS4;
    wire logic [31:0] link_val = pc_ff + link_ofs;

    wire logic [31:0] vector =
        (exc_ff == psw_pkg::EXC_DATA_ABORT) ? psw_pkg::VEC_DATA_ABORT :
        (exc_ff == psw_pkg::EXC_FIQ)  ? psw_pkg::VEC_FIQ  :
        (exc_ff == psw_pkg::EXC_IRQ)  ? psw_pkg::VEC_IRQ  :
        (exc_ff == psw_pkg::EXC_PREFETCH_ABORT) ? psw_pkg::VEC_PREFETCH_ABORT :
        (exc_ff == psw_pkg::EXC_UND)  ? psw_pkg::VEC_UND  :
        psw_pkg::VEC_SWT;

    // Register port decode
    wire logic wr_cur    = WR_I && (ADDR_I == psw_pkg::ADDR_CUR);
    wire logic wr_saved  = WR_I && (ADDR_I == psw_pkg::ADDR_SAVED);
    wire logic wr_return = WR_I && (ADDR_I == psw_pkg::ADDR_RETURN);
    wire logic [2:0] cur_slot = slot_of(cur_mode);
    wire logic entry_wr  = (st_ff == ST_SAVE);

    // Saved words: five, one per exception mode, shared by both states
    wire logic        sv_we    = entry_wr || (wr_saved && cur_slot != psw_pkg::SLOT_NONE);
    wire logic [2:0]  sv_waddr = entry_wr ? slot_of(mode_of(exc_ff)) : cur_slot;
    wire logic [31:0] sv_wdata = entry_wr ? cur_ff : WDATA_I;

    psw_bank_mem #(.DEPTH(psw_pkg::SLOTS), .WIDTH(psw_pkg::WORD_W)) u_saved (
        .clk_i   (CLK_I),
        .we_i    (sv_we),
        .waddr_i (sv_waddr),
        .wdata_i (sv_wdata),
        .raddr_i (cur_slot),
        .rdata_o (saved_rdata)
    );

    // Next current word
    always_comb begin
        nxt_cur = cur_ff;
        if (st_ff == ST_SAVE) begin
            nxt_cur[4:0] = mode_of(exc_ff);
            nxt_cur[psw_pkg::BIT_T] = 1'b0;
            nxt_cur[psw_pkg::BIT_I] = 1'b1;
            if (exc_ff == psw_pkg::EXC_FIQ) begin
                nxt_cur[psw_pkg::BIT_F] = 1'b1;
            end
        end else if (wr_return && cur_slot != psw_pkg::SLOT_NONE) begin
            nxt_cur = saved_rdata;
        end else begin
            if (FLAGS_WE_I) begin
                nxt_cur[31:28] = FLAGS_I;
            end
            if (wr_cur) begin
                nxt_cur[31:28] = WDATA_I[31:28];
                if (privileged) begin
                    nxt_cur[psw_pkg::CTRL_W-1:0] = WDATA_I[psw_pkg::CTRL_W-1:0];
                end
            end
        end
    end

    // Entry sequencer: capture, save, then fetch redirect
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            ST_IDLE:  if (sel != psw_pkg::EXC_NONE) nxt_st = is_trap ? ST_SAVE : ST_IDLE;
            ST_SAVE:  nxt_st = ST_FETCH;
            default:  nxt_st = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            cur_ff  <= psw_pkg::CUR_RESET;
            st_ff   <= ST_IDLE;
            exc_ff  <= psw_pkg::EXC_NONE;
            pc_ff   <= psw_pkg::ZERO_WORD;
            tstate_ff <= 1'b0;
        end else begin
            cur_ff <= nxt_cur;
            st_ff  <= nxt_st;
            if (take && sel != psw_pkg::EXC_NONE) begin
                exc_ff    <= sel;
                pc_ff     <= PC_I;
                tstate_ff <= cur_t;
            end
        end
    end

    // Branch-with-link link write happens without a mode change
    wire logic bl_now = (st_ff == ST_IDLE) && take && (sel == psw_pkg::EXC_BL);
    wire logic [31:0] bl_link = PC_I + (cur_t ? psw_pkg::LINK_OFS2 : psw_pkg::LINK_OFS4);

    // Condition evaluation on flags
    wire logic fn = cur_ff[psw_pkg::BIT_N];
    wire logic fz = cur_ff[psw_pkg::BIT_Z];
    wire logic fc = cur_ff[psw_pkg::BIT_C];
    wire logic fv = cur_ff[psw_pkg::BIT_V];
    logic cond_raw;
    always_comb begin
        case (COND_I[3:1])
            3'h0:    cond_raw = fz;
            3'h1:    cond_raw = fc;
            3'h2:    cond_raw = fn;
            3'h3:    cond_raw = fv;
            3'h4:    cond_raw = fc && !fz;
            3'h5:    cond_raw = (fn == fv);
            3'h6:    cond_raw = !fz && (fn == fv);
            default: cond_raw = 1'b1;
        endcase
    end
    wire logic cond_ok = (COND_I == 4'hF) ? 1'b1 : (cond_raw ^ COND_I[0]);

    // Physical register index: banked per mode, shared low registers
    wire logic fiq_mode = (cur_mode == psw_pkg::MODE_FIQ);
    wire logic [5:0] phys =
        (REG_SEL_I < 4'h8 || REG_SEL_I == 4'hF) ? {2'h0, REG_SEL_I} :
        fiq_mode ? {3'h2, REG_SEL_I[2:0]} + 6'h0 :
        (REG_SEL_I < 4'hD || cur_slot == psw_pkg::SLOT_NONE) ? {2'h0, REG_SEL_I} :
        {1'b1, cur_slot, REG_SEL_I[1:0]};

    // Registered outputs
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            COMPACT_STATE_O  <= 1'b0;
            MODE_O           <= psw_pkg::MODE_SVC;
            COND_PASS_O      <= 1'b0;
            HI_FAULT_O       <= 1'b0;
            PHYS_REG_O       <= '0;
            FETCH_REDIRECT_O <= 1'b1;
            FETCH_ADDR_O     <= psw_pkg::VEC_RESET;
            LINK_WE_O        <= 1'b0;
            LINK_DATA_O      <= psw_pkg::ZERO_WORD;
            BUSY_O           <= 1'b0;
            RDATA_O          <= psw_pkg::ZERO_WORD;
            rd_saved_ff      <= 1'b0;
            rd_slot_ff       <= psw_pkg::SLOT_NONE;
        end else begin
            COMPACT_STATE_O  <= nxt_cur[psw_pkg::BIT_T];
            MODE_O           <= nxt_cur[4:0];
            COND_PASS_O      <= cur_t ? (COND_I == 4'hE || cond_ok) : cond_ok;
            HI_FAULT_O       <= cur_t && HI_ACCESS_I && !HI_LEGAL_I;
            PHYS_REG_O       <= phys;
            FETCH_REDIRECT_O <= (st_ff == ST_SAVE);
            FETCH_ADDR_O     <= (st_ff == ST_SAVE) ? vector : FETCH_ADDR_O;
            LINK_WE_O        <= (st_ff == ST_SAVE) || bl_now;
            LINK_DATA_O      <= (st_ff == ST_SAVE) ? link_val : bl_now ? bl_link : LINK_DATA_O;
            BUSY_O           <= (nxt_st != ST_IDLE);
            rd_saved_ff      <= RD_I && (ADDR_I == psw_pkg::ADDR_SAVED);
            rd_slot_ff       <= cur_slot;
            if (RD_I && ADDR_I == psw_pkg::ADDR_CUR) begin
                RDATA_O <= cur_ff;
            end else if (RD_I && ADDR_I == psw_pkg::ADDR_LINK) begin
                RDATA_O <= LINK_DATA_O;
            end else if (RD_I && ADDR_I == psw_pkg::ADDR_PC) begin
                RDATA_O <= FETCH_ADDR_O;
            end else begin
                RDATA_O <= psw_pkg::ZERO_WORD;
            end
        end
    end

    // Assertions
    chk_mode_force: assert property (@(posedge CLK_I) disable iff (RST_I)
        (st_ff == ST_SAVE) |=> (cur_ff[4:0] == mode_of(exc_ff)))
        else $error("mode not forced on entry");
    chk_full_state: assert property (@(posedge CLK_I) disable iff (RST_I)
        (st_ff == ST_SAVE) |=> !cur_ff[psw_pkg::BIT_T])
        else $error("state bit not cleared on entry");
    chk_compact_state_output_pin: assert property (@(posedge CLK_I) disable iff (RST_I)
        COMPACT_STATE_O == cur_ff[psw_pkg::BIT_T])
        else $error("state pin mismatch");
    chk_user_ctrl: assert property (@(posedge CLK_I) disable iff (RST_I)
        (wr_cur && !privileged && st_ff == ST_IDLE && !wr_return)
        |=> (cur_ff[7:0] == $past(cur_ff[7:0])))
        else $error("user wrote control bits");
    chk_data_abort_link: assert property (@(posedge CLK_I) disable iff (RST_I)
        (st_ff == ST_SAVE && exc_ff == psw_pkg::EXC_DATA_ABORT)
        |=> (LINK_WE_O && LINK_DATA_O == $past(pc_ff) + psw_pkg::LINK_OFS8))
        else $error("data abort link wrong");
    chk_compact_link: assert property (@(posedge CLK_I) disable iff (RST_I)
        (st_ff == ST_SAVE && tstate_ff && exc_ff == psw_pkg::EXC_SWT)
        |=> (LINK_DATA_O == $past(pc_ff) + psw_pkg::LINK_OFS2))
        else $error("compact trap link wrong");
    sequence s_entry;
        (st_ff == ST_SAVE) ##1 (st_ff == ST_FETCH) ##1 (st_ff == ST_IDLE);
    endsequence
    chk_entry_seq: assert property (@(posedge CLK_I) disable iff (RST_I)
        (st_ff == ST_SAVE) |-> s_entry)
        else $error("entry sequence broken");
    chk_fiq_vector: assert property (@(posedge CLK_I) disable iff (RST_I)
        (st_ff == ST_SAVE && exc_ff == psw_pkg::EXC_FIQ)
        |=> (FETCH_REDIRECT_O && FETCH_ADDR_O == psw_pkg::VEC_FIQ))
        else $error("fast vector wrong");
    chk_irq_mask: assert property (@(posedge CLK_I) disable iff (RST_I)
        (sel == psw_pkg::EXC_IRQ) |-> !cur_ff[psw_pkg::BIT_I])
        else $error("masked interrupt taken");
    chk_prio_data_abort: assert property (@(posedge CLK_I) disable iff (RST_I)
        (take && data_abort_req) |-> (sel == psw_pkg::EXC_DATA_ABORT))
        else $error("data abort not first");
endmodule : psw_exc_unit
`default_nettype wire

// >>> testbench/psw_src_model.sv
// Model of the interrupt and abort sources facing the exception unit
`default_nettype none
module psw_src_model (
    // Requests from the bench: {data abort, normal, fast}
    input  wire logic [2:0] req_i,
    // Pins towards the core
    output wire logic       fiq_n_o,
    output wire logic       irq_n_o,
    output wire logic       data_abort_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pins move off the core edge, as an unrelated source would
    assign #7 fiq_n_o = ~req_i[0];
    assign #7 irq_n_o = ~req_i[1];
    assign #7 data_abort_o  = req_i[2];
endmodule : psw_src_model
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the status word and exception unit
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, wr, rd, fwe, iend, swt, und, prefetch_abort, hacc, bl, hleg;
    logic        comp, hfault, redir, lwe, cpass, busy;
    logic [3:0]  addr, flags, rsel, cond;
    logic [2:0]  req;
    logic [4:0]  mode;
    logic [5:0]  phys;
    logic [31:0] wdata, pc, rdata, faddr, ldata;
    wire         fiq_n, irq_n, data_abort;
    int          failures, comparisons;

    psw_exc_unit psw_exc_unit_i (
        .CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .PC_I(pc), .FLAGS_WE_I(fwe), .FLAGS_I(flags), .COND_I(cond),
        .INSN_END_I(iend), .BL_I(bl), .SWT_I(swt), .UND_I(und), .PREFETCH_ABORT_I(prefetch_abort),
        .HI_ACCESS_I(hacc), .HI_LEGAL_I(hleg), .REG_SEL_I(rsel), .FIQ_N_I(fiq_n),
        .IRQ_N_I(irq_n), .DATA_ABORT_I(data_abort), .COMPACT_STATE_O(comp), .MODE_O(mode),
        .COND_PASS_O(cpass), .HI_FAULT_O(hfault), .PHYS_REG_O(phys), .FETCH_REDIRECT_O(redir),
        .FETCH_ADDR_O(faddr), .LINK_WE_O(lwe), .LINK_DATA_O(ldata), .BUSY_O(busy)
    );
    psw_src_model psw_src_model_i (.req_i(req), .fiq_n_o(fiq_n), .irq_n_o(irq_n), .data_abort_o(data_abort));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        // Idle edge: the saved word is read through a register, so a return
        // right after a saved write would pick up the old word
        @(posedge clk);
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp, what);
        @(posedge clk);
    endtask : rd_chk

    // src bits: {trap, undefined, prefetch, data abort, normal, fast}
    task automatic enter(input logic [5:0] src, input logic [31:0] p, input logic hit,
                         input logic [31:0] vec, input logic [4:0] md, input logic [31:0] lk);
        logic seen;
        seen = 1'b0;
        pc <= p;
        req <= src[2:0];
        // Let the pin synchroniser settle so every source is pending at one boundary
        tick(4);
        {swt, und, prefetch_abort} <= src[5:3];
        iend <= 1'b1;
        tick(1);
        {swt, und, prefetch_abort} <= 3'h0;
        iend <= 1'b0;
        repeat (6) begin
            @(posedge clk);
            #1;
            if (redir === 1'b1 && !seen) begin
                seen = 1'b1;
                check({31'h0, comp}, 32'h0, "state");
                check({27'h0, mode}, {27'h0, md}, "mode");
                check(faddr, vec, "vector");
                check(ldata, lk, "link");
                check({31'h0, lwe}, 32'h1, "link strobe");
                check({31'h0, busy}, 32'h1, "busy");
            end
        end
        check({31'h0, seen}, {31'h0, hit}, "taken");
        @(posedge clk);
        req <= 3'h0;
        tick(4);
    endtask : enter

    task automatic round(input logic [5:0] src, input logic [31:0] p, input logic [31:0] vec,
                         input logic [4:0] md, input logic [31:0] lk);
        logic fast;
        fast = (md == psw_pkg::MODE_FIQ);
        enter(src, p, 1'b1, vec, md, lk);
        rd_chk(psw_pkg::ADDR_CUR, {24'h0, 1'b1, fast, 1'b0, md}, "entry word");
        rd_chk(psw_pkg::ADDR_LINK, lk, "link read");
        rd_chk(psw_pkg::ADDR_PC, vec, "vector read");
        rsel <= 4'h8;
        @(posedge clk);
        #1;
        check({26'h0, phys}, fast ? 32'h10 : 32'h8, "bank");
        @(posedge clk);
        wr_reg(psw_pkg::ADDR_RETURN, 32'h0);
        rd_chk(psw_pkg::ADDR_CUR, 32'h30, "restored");
    endtask : round

    task automatic print_verdict();
        if (failures == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    initial begin
        tick(3000);
        failures++;
        print_verdict();
    end

    initial begin
        {rst, wr, rd, fwe, iend, swt, und, prefetch_abort, hacc, bl, hleg} = 11'h400;
        addr = 4'h0;
        flags = 4'h0;
        cond = 4'h0;
        rsel = 4'h0;
        req = 3'h0;
        wdata = 32'h0;
        pc = 32'h0;
        failures = 0;
        comparisons = 0;
        tick(6);
        rst <= 1'b0;
        #1;
        check({27'h0, mode}, {27'h0, psw_pkg::MODE_SVC}, "reset mode");
        check(faddr, psw_pkg::VEC_RESET, "reset vector");
        @(posedge clk);
        rd_chk(psw_pkg::ADDR_CUR, psw_pkg::CUR_RESET, "reset word");
        // Both masks are set out of reset, so neither interrupt may be taken
        enter(6'h02, 32'h0, 1'b0, 32'h0, 5'h0, 32'h0);
        enter(6'h01, 32'h0, 1'b0, 32'h0, 5'h0, 32'h0);
        rsel <= 4'hD;
        fwe <= 1'b1;
        flags <= 4'h6;
        @(posedge clk);
        fwe <= 1'b0;
        #1;
        check({26'h0, phys}, 32'h29, "svc bank");
        @(posedge clk);
        rd_chk(psw_pkg::ADDR_CUR, 32'h600000D3, "flags");
        check({31'h0, cpass}, 32'h1, "cond eq");
        cond <= 4'h1;
        @(posedge clk);
        #1;
        check({31'h0, cpass}, 32'h0, "cond ne");
        @(posedge clk);
        // Compact state is reached here through a return; a privileged write to the current word can also set it
        wr_reg(psw_pkg::ADDR_SAVED, 32'h00000030);
        wr_reg(psw_pkg::ADDR_RETURN, 32'h0);
        rd_chk(psw_pkg::ADDR_CUR, 32'h30, "user compact");
        check({31'h0, comp}, 32'h1, "state pin");
        wr_reg(psw_pkg::ADDR_CUR, 32'h000000F0);
        rd_chk(psw_pkg::ADDR_CUR, 32'h30, "user write");
        hacc <= 1'b1;
        @(posedge clk);
        #1;
        check({31'h0, hfault}, 32'h1, "hi access");
        check({26'h0, phys}, 32'hD, "shared sp");
        @(posedge clk);
        hleg <= 1'b1;
        @(posedge clk);
        #1;
        check({31'h0, hfault}, 32'h0, "legal hi");
        @(posedge clk);
        hacc <= 1'b0;
        hleg <= 1'b0;
        pc <= 32'h900;
        bl <= 1'b1;
        iend <= 1'b1;
        @(posedge clk);
        bl <= 1'b0;
        iend <= 1'b0;
        #1;
        check(ldata, 32'h902, "bl link");
        check({31'h0, lwe}, 32'h1, "bl strobe");
        check({27'h0, mode}, {27'h0, psw_pkg::MODE_USR}, "bl mode");
        @(posedge clk);
        round(6'h10, 32'h100, psw_pkg::VEC_UND, psw_pkg::MODE_UND, 32'h102);
        round(6'h20, 32'h200, psw_pkg::VEC_SWT, psw_pkg::MODE_SVC, 32'h202);
        round(6'h08, 32'h300, psw_pkg::VEC_PREFETCH_ABORT, psw_pkg::MODE_ABT, 32'h304);
        round(6'h04, 32'h400, psw_pkg::VEC_DATA_ABORT, psw_pkg::MODE_ABT, 32'h408);
        round(6'h02, 32'h500, psw_pkg::VEC_IRQ, psw_pkg::MODE_IRQ, 32'h504);
        round(6'h01, 32'h600, psw_pkg::VEC_FIQ, psw_pkg::MODE_FIQ, 32'h604);
        round(6'h07, 32'h700, psw_pkg::VEC_DATA_ABORT, psw_pkg::MODE_ABT, 32'h708);
        round(6'h18, 32'h800, psw_pkg::VEC_PREFETCH_ABORT, psw_pkg::MODE_ABT, 32'h804);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
